/* File: rtl/rate_event_pkg.sv */
/*
 * Constants, register map and carrier types for the rate threshold event unit.
 * Assumes an 8-bit register port from the host interface and 16-bit signed rate samples.
 */
package rate_event_pkg;

    // ------------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_FILTER_SELECT = 8'h24;
    localparam logic [7:0] ADDR_EVENT_CONFIG = 8'h30;
    localparam logic [7:0] ADDR_EVENT_SOURCE = 8'h31;
    localparam logic [7:0] ADDR_X_THRESHOLD_HIGH = 8'h32;
    localparam logic [7:0] ADDR_X_THRESHOLD_LOW = 8'h33;
    localparam logic [7:0] ADDR_Y_THRESHOLD_HIGH = 8'h34;
    localparam logic [7:0] ADDR_Y_THRESHOLD_LOW = 8'h35;
    localparam logic [7:0] ADDR_Z_THRESHOLD_HIGH = 8'h36;
    localparam logic [7:0] ADDR_Z_THRESHOLD_LOW = 8'h37;
    localparam logic [7:0] ADDR_DURATION = 8'h38;

    // ------------------------------------------------------------------
    // Field positions and widths.
    // ------------------------------------------------------------------
    localparam int AXES = 3;
    localparam int THRESHOLD_WIDTH = 15;
    localparam int RATE_WIDTH = 16;
    localparam int DURATION_WIDTH = 7;
    localparam int CFG_COMBINE_BIT = 7;
    localparam int CFG_LATCH_BIT = 6;
    localparam int DUR_WAIT_BIT = 7;
    localparam int SELECT_LSB = 2;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UPPER_MASK = 8'h7F;
    localparam logic [1:0] SEL_RAW = 2'h0;
    localparam logic [1:0] SEL_HIGH_PASS = 2'h1;

    typedef logic [7:0] byte_t;

    // Host register port request.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // One rate sample of each filter path, X in the low slice.
    typedef struct packed {
        logic valid;
        logic [AXES*RATE_WIDTH-1:0] raw;
        logic [AXES*RATE_WIDTH-1:0] high_pass;
        logic [AXES*RATE_WIDTH-1:0] low_pass;
        logic [AXES*RATE_WIDTH-1:0] band_pass;
    } rate_sample_s;

endpackage

/* File: rtl/rate_persist_filter.sv */
/*
 * Persistence filter for one comparison condition.
 * Assumes one enable pulse per output data sample on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module rate_persist_filter
#(
    parameter int DW = 7
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic sample,
    input wire logic cond,
    input wire logic [DW-1:0] duration,
    input wire logic wait_en,
    output logic active
);
    typedef struct packed {
        logic active;
        logic [DW-1:0] count;
    } state_s;

    state_s st;
    state_s next_st;

    always_comb
    begin
        next_st = st;
        if (sample)
        begin
            if (cond == st.active)
            begin
                next_st.count = '0;
            end
            else if (!cond && !wait_en)
            begin
                next_st.active = 1'b0;
                next_st.count = '0;
            end
            else if (st.count >= duration)
            begin
                next_st.active = cond;
                next_st.count = '0;
            end
            else
            begin
                next_st.count = st.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            st <= '0;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign active = st.active;
endmodule
`default_nettype wire

/* File: rtl/rate_threshold_event_unit.sv */
/*
 * Threshold event unit of a three-axis angular rate sensor: configuration,
 * thresholds, duration, source register and the event output pin.
 * Assumes the serial interface delivers one-cycle read and write strobes on clk_sys,
 * and the filter chain delivers one sample strobe per output data period.
 */
// Overview of operation
// - Combine bit chooses OR or AND of events
// - Latch bit holds flags once set
// - Per-axis high enable, reset zero
// - High event when rate magnitude exceeds threshold
// - Per-axis low enable, below threshold
// - Active flag set when events generated
// - Six per-axis high and low flags
// - Source register ignores host writes
// - Reading source clears active flag unless latched with event still live
// - Reading source drops the event pin unless latched with event still live
// - Latched flags refresh only after read
// - Fifteen-bit thresholds split over two bytes
// - Threshold bytes reset to zero
// - Z threshold at 36h and 37h
// - Duration sets minimum persisting samples
// - Wait bit delays event release
// - Select field picks filtered data path
`timescale 1ns/10ps
`default_nettype none
module rate_threshold_event_unit
    import rate_event_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire rate_event_pkg::reg_req_s req,
    input wire rate_event_pkg::rate_sample_s rate,
    output logic [7:0] rdata,
    output logic event_output_pin
);

    typedef struct packed {
        byte_t config_reg;
        logic [1:0] event_source_select;
        logic [AXES-1:0][6:0] th_upper;
        logic [AXES-1:0][7:0] th_lower;
        byte_t duration_reg;
        logic [5:0] flags;
        logic event_active;
        logic pin;
        byte_t rdata;
    } state_s;

    state_s st;
    state_s next_st;

    logic [AXES*RATE_WIDTH-1:0] chosen;
    logic [2*AXES-1:0] cond;
    logic [2*AXES-1:0] persisted;
    logic [2*AXES-1:0] enables;
    logic [5:0] live_flags;
    logic combined;
    logic src_read;

    // ------------------------------------------------------------------
    // Data path selection and comparison.
    // ------------------------------------------------------------------
    always_comb
    begin
        if (st.event_source_select[1])
        begin
            chosen = st.event_source_select[0] ? rate.band_pass : rate.low_pass;
        end
        else if (st.event_source_select == SEL_HIGH_PASS)
        begin
            chosen = rate.high_pass;
        end
        else
        begin
            chosen = rate.raw;
        end
    end

    assign enables = st.config_reg[5:0];

    for (genvar a = 0; a < AXES; a++)
    begin : g_axis
        logic signed [RATE_WIDTH-1:0] s;
        logic [RATE_WIDTH:0] mag;
        logic [RATE_WIDTH:0] th;
        assign s = chosen[a*RATE_WIDTH +: RATE_WIDTH];
        assign mag = s[RATE_WIDTH-1] ? (RATE_WIDTH+1)'(-$signed({s[RATE_WIDTH-1], s}))
                                     : {1'b0, s};
        assign th = {2'b00, st.th_upper[a], st.th_lower[a]};
        assign cond[2*a+1] = mag > th;
        assign cond[2*a] = mag < th;
    end

    for (genvar e = 0; e < 2*AXES; e++)
    begin : g_persist
        rate_persist_filter #(.DW(DURATION_WIDTH)) u_filter
        (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .ce(ce),
            .sample(rate.valid),
            .cond(cond[e]),
            .duration(st.duration_reg[DURATION_WIDTH-1:0]),
            .wait_en(st.duration_reg[DUR_WAIT_BIT]),
            .active(persisted[e])
        );
    end

    assign live_flags = persisted & enables;
    assign src_read = req.rd && (req.addr == ADDR_EVENT_SOURCE);

    always_comb
    begin
        if (enables == '0)
        begin
            combined = 1'b0;
        end
        else if (st.config_reg[CFG_COMBINE_BIT])
        begin
            combined = ((live_flags & enables) == enables);
        end
        else
        begin
            combined = |live_flags;
        end
    end

    // ------------------------------------------------------------------
    // Register file and event state.
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        if (req.wr)
        begin
            if (req.addr == ADDR_EVENT_CONFIG)
            begin
                next_st.config_reg = req.wdata;
            end
            else if (req.addr == ADDR_FILTER_SELECT)
            begin
                next_st.event_source_select = req.wdata[SELECT_LSB +: 2];
            end
            else if (req.addr == ADDR_X_THRESHOLD_HIGH)
            begin
                next_st.th_upper[0] = req.wdata[6:0];
            end
            else if (req.addr == ADDR_X_THRESHOLD_LOW)
            begin
                next_st.th_lower[0] = req.wdata;
            end
            else if (req.addr == ADDR_Y_THRESHOLD_HIGH)
            begin
                next_st.th_upper[1] = req.wdata[6:0];
            end
            else if (req.addr == ADDR_Y_THRESHOLD_LOW)
            begin
                next_st.th_lower[1] = req.wdata;
            end
            else if (req.addr == ADDR_Z_THRESHOLD_HIGH)
            begin
                next_st.th_upper[2] = req.wdata[6:0];
            end
            else if (req.addr == ADDR_Z_THRESHOLD_LOW)
            begin
                next_st.th_lower[2] = req.wdata;
            end
            else if (req.addr == ADDR_DURATION)
            begin
                next_st.duration_reg = req.wdata;
            end
            // Writes to the source register fall through untouched.
        end

        if (req.rd)
        begin
            if (req.addr == ADDR_EVENT_CONFIG)
            begin
                next_st.rdata = st.config_reg;
            end
            else if (req.addr == ADDR_EVENT_SOURCE)
            begin
                next_st.rdata = {1'b0, st.event_active, st.flags};
            end
            else if (req.addr == ADDR_FILTER_SELECT)
            begin
                next_st.rdata = {4'h0, st.event_source_select, 2'b00};
            end
            else if (req.addr == ADDR_X_THRESHOLD_HIGH)
            begin
                next_st.rdata = {1'b0, st.th_upper[0]};
            end
            else if (req.addr == ADDR_X_THRESHOLD_LOW)
            begin
                next_st.rdata = st.th_lower[0];
            end
            else if (req.addr == ADDR_Y_THRESHOLD_HIGH)
            begin
                next_st.rdata = {1'b0, st.th_upper[1]};
            end
            else if (req.addr == ADDR_Y_THRESHOLD_LOW)
            begin
                next_st.rdata = st.th_lower[1];
            end
            else if (req.addr == ADDR_Z_THRESHOLD_HIGH)
            begin
                next_st.rdata = {1'b0, st.th_upper[2]};
            end
            else if (req.addr == ADDR_Z_THRESHOLD_LOW)
            begin
                next_st.rdata = st.th_lower[2];
            end
            else if (req.addr == ADDR_DURATION)
            begin
                next_st.rdata = st.duration_reg;
            end
            else
            begin
                next_st.rdata = REG_RESET;
            end
        end

        // Flags follow the filtered comparison unless latched and still unread.
        if (st.config_reg[CFG_LATCH_BIT])
        begin
            if (src_read)
            begin
                next_st.flags = live_flags;
                next_st.event_active = combined;
            end
            else
            begin
                next_st.flags = st.flags | live_flags;
                next_st.event_active = st.event_active | combined;
            end
        end
        else
        begin
            next_st.flags = live_flags;
            next_st.event_active = combined && !src_read;
            if (src_read)
            begin
                next_st.event_active = 1'b0;
            end
        end
        next_st.pin = next_st.event_active;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            st <= '0;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign event_output_pin = st.pin;
endmodule
`default_nettype wire

/* File: sim/rate_event_monitor.sv */
/* Checker for the rate threshold event unit.
   Assumes it sees only the unit's top-level ports. */
`timescale 1ns/10ps
`default_nettype none
module rate_event_monitor
    import rate_event_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire rate_event_pkg::reg_req_s req,
    input wire rate_event_pkg::rate_sample_s rate,
    input wire logic [7:0] rdata,
    input wire logic event_output_pin
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence src_rd;
        ce && req.rd && req.addr == ADDR_EVENT_SOURCE;
    endsequence
    sequence pin_cause;
        $past(rate.valid, 2) || $past(req.rd) || $past(req.rd, 2) || $past(req.wr, 2);
    endsequence
    reset_quiet_a: assert property ($rose(nrst) |-> rdata == 8'h00 && !event_output_pin)
        else $error("outputs not clear after reset");
    read_active_a: assert property (src_rd |=> rdata[6] == $past(event_output_pin))
        else $error("active flag read differs from pin");
    src_top_a: assert property (src_rd |=> !rdata[7])
        else $error("source top bit not zero");
    ths_top_a: assert property (ce && req.rd && req.addr inside {8'h32, 8'h34, 8'h36}
        |=> !rdata[7]) else $error("threshold top bit not zero");
    unmapped_zero_a: assert property (ce && req.rd && req.addr == 8'h3F |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!(ce && req.rd) |=> $stable(rdata))
        else $error("read data changed without a read");
    pin_rise_a: assert property ($rose(event_output_pin) |-> pin_cause)
        else $error("pin rose without sample or read");
    pin_fall_a: assert property ($fell(event_output_pin) |-> pin_cause)
        else $error("pin fell without sample or read");
    freeze_a: assert property (!ce |=> $stable(rdata) && $stable(event_output_pin))
        else $error("outputs moved while clock enable low");
endmodule
bind rate_threshold_event_unit rate_event_monitor mon (.clk_sys(clk_sys), .nrst(nrst),
    .ce(ce), .req(req), .rate(rate), .rdata(rdata), .event_output_pin(event_output_pin));
`default_nettype wire

/* File: sim/rate_source_model.sv */
/* Model of the filter chain that feeds rate samples.
   Assumes the bench pulses fire for one cycle per sample. */
`timescale 1ns/10ps
`default_nettype none
module rate_source_model
    import rate_event_pkg::*;
(
    input wire logic fire,
    input wire logic [1:0] path,
    input wire logic [47:0] vec,
    output var rate_event_pkg::rate_sample_s rate
);
    logic [47:0] d;
    logic [47:0] z;
    // Outside a sample the selected path shows the inverse, never a stale value; the other paths stay zero.
    assign d = fire ? vec : ~vec;
    assign z = 48'h0000_0000_0000;
    assign rate = {fire, path == 2'h0 ? d : z, path == 2'h1 ? d : z, path == 2'h2 ? d : z,
        path == 2'h3 ? d : z};
endmodule
`default_nettype wire

/* File: sim/test_rate_threshold_event_unit.sv */
/* Self-checking bench for the rate threshold event unit.
   Assumes the package, the unit, the checker and the source model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module test_rate_threshold_event_unit;
    import rate_event_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic fire = 1'b0;
    logic [1:0] path = 2'h0;
    logic [47:0] vec = 48'h0000_0000_0000;
    reg_req_s req = '0;
    rate_sample_s rate;
    logic [7:0] rdata;
    logic event_output_pin;
    logic [7:0] got;
    int err_total = 0;
    int samples_checked = 0;
    always #50 clk_sys = ~clk_sys;
    rate_source_model src (.fire(fire), .path(path), .vec(vec), .rate(rate));
    rate_threshold_event_unit uut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .req(req),
        .rate(rate), .rdata(rdata), .event_output_pin(event_output_pin));
    // ------------------------------------------------------------------
    // Access tasks.
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic pin(input logic e);
        chk({7'h00, event_output_pin}, {7'h00, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk_sys);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        req <= '0;
        @(negedge clk_sys);
        got = rdata;
    endtask
    task automatic samp(input logic [15:0] x, input logic [15:0] y, input logic [1:0] p);
        @(posedge clk_sys);
        fire <= 1'b1;
        vec <= {16'h0000, y, x};
        path <= p;
        @(posedge clk_sys);
        fire <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic close_out();
        $display("Checks %0d, errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int a = 'h30; a <= 'h38; a++)
        begin
            rd(8'(a));
            chk(got, 8'h00);
        end
        rd(8'h3F);
        chk(got, 8'h00);
        wr(8'h36, 8'hFF);
        rd(8'h36);
        chk(got, 8'h7F);
        wr(8'h37, 8'hA5);
        rd(8'h37);
        chk(got, 8'hA5);
        wr(8'h31, 8'hFF);
        rd(8'h31);
        chk(got, 8'h00);
        wr(8'h33, 8'h32);
        wr(8'h35, 8'h32);
        wr(8'h30, 8'h02);
        samp(16'h0064, 16'h0032, 2'h0);
        pin(1'b1);
        rd(8'h31);
        pin(1'b0);
        chk(got, 8'h42);
        samp(16'hFF9C, 16'h0032, 2'h0);
        rd(8'h31);
        chk(got, 8'h42);
        wr(8'h30, 8'h01);
        samp(16'hFFF6, 16'h0032, 2'h0);
        rd(8'h31);
        chk(got, 8'h41);
        samp(16'h0064, 16'h0032, 2'h0);
        pin(1'b0);
        wr(8'h30, 8'h8A);
        samp(16'h0064, 16'h000A, 2'h0);
        pin(1'b0);
        samp(16'h0064, 16'h0064, 2'h0);
        pin(1'b1);
        wr(8'h30, 8'h0A);
        samp(16'h000A, 16'h0064, 2'h0);
        pin(1'b1);
        @(posedge clk_sys);
        ce <= 1'b0;
        samp(16'h000A, 16'h000A, 2'h0);
        @(posedge clk_sys);
        ce <= 1'b1;
        @(negedge clk_sys);
        pin(1'b1);
        wr(8'h30, 8'h42);
        samp(16'h000A, 16'h0032, 2'h0);
        rd(8'h31);
        samp(16'h0064, 16'h0032, 2'h0);
        samp(16'h000A, 16'h0032, 2'h0);
        pin(1'b1);
        rd(8'h31);
        chk(got, 8'h42);
        pin(1'b0);
        rd(8'h31);
        chk(got, 8'h00);
        wr(8'h30, 8'h02);
        wr(8'h38, 8'h82);
        samp(16'h0064, 16'h0032, 2'h0);
        samp(16'h0064, 16'h0032, 2'h0);
        pin(1'b0);
        samp(16'h0064, 16'h0032, 2'h0);
        pin(1'b1);
        samp(16'h000A, 16'h0032, 2'h0);
        pin(1'b1);
        repeat (3) samp(16'h000A, 16'h0032, 2'h0);
        pin(1'b0);
        wr(8'h38, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h24, 8'(s << 2));
            rd(8'h24);
            chk(got, 8'(s << 2));
            samp(16'h0064, 16'h0032, ~2'(s));
            pin(1'b0);
            samp(16'h0064, 16'h0032, 2'(s));
            pin(1'b1);
        end
        wr(8'h24, 8'h00);
        wr(8'h32, 8'h01);
        samp(16'h0100, 16'h0032, 2'h0);
        pin(1'b0);
        samp(16'h0140, 16'h0032, 2'h0);
        pin(1'b1);
        close_out();
    end
endmodule
`default_nettype wire
